// ---- csd_gain_decode.sv ----
// Purpose: Decode one 4-bit current-sense gain code
// Assumes: Purely combinational, fed from a register
// Notes: Output gain is four times the real gain
module csd_gain_decode
(
  // Raw code
  input wire logic [3:0] code_raw,
  // Decoded result
  output logic [3:0] code_eff,
  output logic [11:0] gain_x4
);
  import csd_pkg::*;

  always_comb
  begin
    if (code_raw > CSD_GAIN_MAX_CODE)
    begin
      code_eff = CSD_GAIN_DEF_CODE;
    end
    else
    begin
      code_eff = code_raw;
    end
    gain_x4 = CSD_GAIN_X4_TAB[code_eff];
  end

endmodule

// ---- csd_pkg.sv ----
// Purpose: Shared constants and carriers for the current-sense and DAC clamp register bank
// Assumes: 32-bit APB, one aligned word per register, byte address is four times the index
// Notes: Gain values are carried as four times the real gain so that all are whole numbers
package csd_pkg;

  localparam int CSD_AW = 8;
  localparam int CSD_IW = 6;

  // Register indices; byte address is index times four
  localparam logic [CSD_IW-1:0] CSD_IDX_BG = 6'h1c;
  localparam logic [CSD_IW-1:0] CSD_IDX_GAIN = 6'h1d;
  localparam logic [CSD_IW-1:0] CSD_IDX_CLAMP0 = 6'h1f;
  localparam logic [CSD_IW-1:0] CSD_IDX_CLAMP1 = 6'h20;

  // Writable bits and reset values
  localparam logic [15:0] CSD_BG_MASK = 16'h0f0f;
  localparam logic [15:0] CSD_GAIN_MASK = 16'hffff;
  localparam logic [15:0] CSD_CLAMP_MASK = 16'hffff;
  localparam logic [15:0] CSD_BG_RST = 16'h0000;
  localparam logic [15:0] CSD_GAIN_RST = 16'h0000;
  localparam logic [15:0] CSD_CLAMP_RST = 16'hff00;

  // Field positions
  localparam int CSD_BGEN_LSB = 0;
  localparam int CSD_FILT_LSB = 8;
  localparam int CSD_SLP_UNI_LSB = 0;
  localparam int CSD_SLP_BI_LSB = 4;
  localparam int CSD_SNZ_UNI_LSB = 8;
  localparam int CSD_SNZ_BI_LSB = 12;
  localparam int CSD_GAIN_W = 4;
  localparam int CSD_NCH = 4;

  // Gain codes and gain times four, code 0 rightmost
  localparam logic [3:0] CSD_GAIN_MAX_CODE = 4'ha;
  localparam logic [3:0] CSD_GAIN_DEF_CODE = 4'h0;
  localparam logic [10:0][11:0] CSD_GAIN_X4_TAB = {
    12'hc35, 12'h640, 12'h320, 12'h190, 12'h12c, 12'h0c8,
    12'h096, 12'h064, 12'h04b, 12'h032, 12'h019};

  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [CSD_AW-1:0] paddr;
    logic [31:0] pwdata;
  } csd_apb_req_t;

  typedef struct packed {
    logic [3:0] filt_en;
    logic [3:0] bg_en;
    logic [3:0][3:0] gain_code;
    logic [3:0][11:0] gain_x4;
  } csd_isense_cfg_t;

  typedef struct packed {
    logic [3:0] bi_clamp;
    logic [3:0] uni_clamp;
    logic [3:0] bi_snooze;
    logic [3:0] uni_snooze;
  } csd_dac_ctl_t;

  typedef struct packed {
    logic [15:0] bg;
    logic [15:0] gain;
    logic [15:0] clamp0;
    logic [15:0] clamp1;
    logic [1:0] pin_s1;
    logic [1:0] pin_s2;
    logic [31:0] rdata;
    csd_isense_cfg_t cfg;
    csd_dac_ctl_t dac;
  } csd_state_t;

endpackage

// ---- csd_regs.sv ----
// Purpose: APB register bank for current-sense setup and DAC clamp pin control
// Assumes: Clamp pins are asynchronous and active high
// Notes: Zero-wait slave; read data is captured in the setup cycle
//
// Added by the designer: the APB register port.
module csd_regs
(
  // Clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // APB slave
  input wire csd_pkg::csd_apb_req_t apb_req,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  // Clamp pins
  input wire logic first_clamp_pin,
  input wire logic second_clamp_pin,
  // Block controls
  output csd_pkg::csd_isense_cfg_t isense_cfg,
  output csd_pkg::csd_dac_ctl_t dac_ctl
);
  import csd_pkg::*;

  csd_state_t st_reg;
  csd_state_t st_next;
  logic [CSD_NCH-1:0][3:0] dec_code;
  logic [CSD_NCH-1:0][11:0] dec_x4;
  logic [CSD_IW-1:0] idx;
  logic aligned;
  logic hit_bg;
  logic hit_gain;
  logic hit_c0;
  logic hit_c1;
  logic mapped;
  logic setup;
  logic access;
  logic wr;

  // Address decode
  assign idx = apb_req.paddr[CSD_AW-1:2];
  assign aligned = (apb_req.paddr[1:0] == 2'h0);
  assign hit_bg = aligned && (idx == CSD_IDX_BG);
  assign hit_gain = aligned && (idx == CSD_IDX_GAIN);
  assign hit_c0 = aligned && (idx == CSD_IDX_CLAMP0);
  assign hit_c1 = aligned && (idx == CSD_IDX_CLAMP1);
  assign mapped = hit_bg || hit_gain || hit_c0 || hit_c1;
  assign setup = apb_req.psel && !apb_req.penable;
  assign access = apb_req.psel && apb_req.penable;
  assign wr = access && apb_req.pwrite && mapped;

  // One decoder per channel
  genvar g;
  generate
    for (g = 0; g < CSD_NCH; g++)
    begin : gen_dec
      csd_gain_decode u_dec
      (
        .code_raw(st_reg.gain[g*CSD_GAIN_W +: CSD_GAIN_W]),
        .code_eff(dec_code[g]),
        .gain_x4(dec_x4[g])
      );
    end
  endgenerate

  always_comb
  begin
    st_next = st_reg;

    // Pin synchroniser
    st_next.pin_s1 = {second_clamp_pin, first_clamp_pin};
    st_next.pin_s2 = st_reg.pin_s1;

    // Register writes, reserved bits masked
    if (wr && hit_bg)
    begin
      st_next.bg = apb_req.pwdata[15:0] & CSD_BG_MASK;
    end
    if (wr && hit_gain)
    begin
      st_next.gain = apb_req.pwdata[15:0] & CSD_GAIN_MASK;
    end
    if (wr && hit_c0)
    begin
      st_next.clamp0 = apb_req.pwdata[15:0] & CSD_CLAMP_MASK;
    end
    if (wr && hit_c1)
    begin
      st_next.clamp1 = apb_req.pwdata[15:0] & CSD_CLAMP_MASK;
    end

    // Read data held for the access phase
    if (setup)
    begin
      st_next.rdata = 32'h0;
      if (hit_bg)
      begin
        st_next.rdata = {16'h0, st_reg.bg};
      end
      if (hit_gain)
      begin
        st_next.rdata = {16'h0, st_reg.gain};
      end
      if (hit_c0)
      begin
        st_next.rdata = {16'h0, st_reg.clamp0};
      end
      if (hit_c1)
      begin
        st_next.rdata = {16'h0, st_reg.clamp1};
      end
    end

    // Current-sense controls
    st_next.cfg.filt_en = st_next.bg[CSD_FILT_LSB +: CSD_NCH];
    st_next.cfg.bg_en = st_next.bg[CSD_BGEN_LSB +: CSD_NCH];
    st_next.cfg.gain_code = dec_code;
    st_next.cfg.gain_x4 = dec_x4;

    // Clamp when a pin is up and allowed; only the second sync stage feeds logic
    st_next.dac.bi_clamp =
      ({4{st_reg.pin_s2[0]}} & st_next.clamp0[CSD_SLP_BI_LSB +: 4]) |
      ({4{st_reg.pin_s2[1]}} & st_next.clamp1[CSD_SLP_BI_LSB +: 4]);
    st_next.dac.uni_clamp =
      ({4{st_reg.pin_s2[0]}} & st_next.clamp0[CSD_SLP_UNI_LSB +: 4]) |
      ({4{st_reg.pin_s2[1]}} & st_next.clamp1[CSD_SLP_UNI_LSB +: 4]);

    // Snooze only on a clamp by the same pin
    st_next.dac.bi_snooze =
      ({4{st_reg.pin_s2[0]}} & st_next.clamp0[CSD_SLP_BI_LSB +: 4] &
       st_next.clamp0[CSD_SNZ_BI_LSB +: 4]) |
      ({4{st_reg.pin_s2[1]}} & st_next.clamp1[CSD_SLP_BI_LSB +: 4] &
       st_next.clamp1[CSD_SNZ_BI_LSB +: 4]);
    st_next.dac.uni_snooze =
      ({4{st_reg.pin_s2[0]}} & st_next.clamp0[CSD_SLP_UNI_LSB +: 4] &
       st_next.clamp0[CSD_SNZ_UNI_LSB +: 4]) |
      ({4{st_reg.pin_s2[1]}} & st_next.clamp1[CSD_SLP_UNI_LSB +: 4] &
       st_next.clamp1[CSD_SNZ_UNI_LSB +: 4]);
  end

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg <= '0;
      st_reg.bg <= CSD_BG_RST;
      st_reg.gain <= CSD_GAIN_RST;
      st_reg.clamp0 <= CSD_CLAMP_RST;
      st_reg.clamp1 <= CSD_CLAMP_RST;
      st_reg.cfg.gain_x4 <= {CSD_NCH{CSD_GAIN_X4_TAB[0]}};
    end
    else
    begin
      st_reg <= st_next;
    end
  end

  // Outputs
  assign pready = 1'b1;
  assign pslverr = access && !mapped;
  assign prdata = st_reg.rdata;
  assign isense_cfg = st_reg.cfg;
  assign dac_ctl = st_reg.dac;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);

  logic wr_bg;
  logic wr_gain;
  logic wr_c0;
  logic wr_c1;
  logic quiet;
  assign wr_bg = wr && hit_bg;
  assign wr_gain = wr && hit_gain;
  assign wr_c0 = wr && hit_c0;
  assign wr_c1 = wr && hit_c1;
  assign quiet = !apb_req.psel;

  a_filt_follow: assert property (
    wr_bg |=> isense_cfg.filt_en == $past(apb_req.pwdata[11:8]))
  else
    $error("filter enables do not follow write");

  a_bgen_follow: assert property (
    wr_bg |=> isense_cfg.bg_en == $past(apb_req.pwdata[3:0]))
  else
    $error("background enables do not follow write");

  a_gain_field_ch3: assert property (
    wr_gain && apb_req.pwdata[15:12] <= CSD_GAIN_MAX_CODE
    ##1 quiet
    |=> isense_cfg.gain_code[3] == $past(apb_req.pwdata[15:12], 2))
  else
    $error("channel 3 gain field misplaced");

  a_gain_field_ch0: assert property (
    wr_gain && apb_req.pwdata[3:0] <= CSD_GAIN_MAX_CODE
    ##1 quiet
    |=> isense_cfg.gain_code[0] == $past(apb_req.pwdata[3:0], 2))
  else
    $error("channel 0 gain field misplaced");

  a_gain_table: assert property (
    isense_cfg.gain_x4[1] == CSD_GAIN_X4_TAB[isense_cfg.gain_code[1]] &&
    isense_cfg.gain_x4[2] == CSD_GAIN_X4_TAB[isense_cfg.gain_code[2]])
  else
    $error("gain value does not match code");

  a_gain_top: assert property (
    wr_gain && apb_req.pwdata[7:4] == CSD_GAIN_MAX_CODE
    ##1 quiet
    |=> isense_cfg.gain_x4[1] == 12'hc35)
  else
    $error("top gain code wrong");

  a_gain_over: assert property (
    wr_gain && apb_req.pwdata[11:8] > CSD_GAIN_MAX_CODE
    ##1 quiet
    |=> isense_cfg.gain_code[2] == CSD_GAIN_DEF_CODE &&
        isense_cfg.gain_x4[2] == 12'h019)
  else
    $error("illegal gain code not mapped to default");

  a_pin_split: assert property (
    wr_c0 |=> $stable(st_reg.clamp1) && st_reg.clamp0 == $past(apb_req.pwdata[15:0]))
  else
    $error("first clamp register write leaked");

  a_clamp_first: assert property (
    (first_clamp_pin && !second_clamp_pin && quiet) [*4]
    |-> dac_ctl.bi_clamp == st_reg.clamp0[7:4] &&
        dac_ctl.uni_clamp == st_reg.clamp0[3:0])
  else
    $error("first pin clamp map wrong");

  a_clamp_second: assert property (
    (second_clamp_pin && !first_clamp_pin && quiet) [*4]
    |-> dac_ctl.bi_clamp == st_reg.clamp1[7:4] &&
        dac_ctl.uni_clamp == st_reg.clamp1[3:0])
  else
    $error("second pin clamp map wrong");

  a_clamp_none: assert property (
    st_reg.clamp0[7:0] == 8'h00 && st_reg.clamp1[7:0] == 8'h00
    |-> dac_ctl.bi_clamp == 4'h0 && dac_ctl.uni_clamp == 4'h0)
  else
    $error("clamp without permission");

  a_snooze_sub: assert property (
    (dac_ctl.bi_snooze & ~dac_ctl.bi_clamp) == 4'h0 &&
    (dac_ctl.uni_snooze & ~dac_ctl.uni_clamp) == 4'h0)
  else
    $error("snooze without clamp");

  a_snooze_both: assert property (
    (first_clamp_pin && second_clamp_pin && quiet) [*4]
    |-> dac_ctl.bi_snooze ==
        ((st_reg.clamp0[7:4] & st_reg.clamp0[15:12]) |
         (st_reg.clamp1[7:4] & st_reg.clamp1[15:12])))
  else
    $error("snooze map wrong");

  a_rsvd_read: assert property (
    setup && !apb_req.pwrite && hit_bg
    |=> prdata[31:12] == 20'h0 && prdata[7:4] == 4'h0)
  else
    $error("reserved bits read nonzero");

  a_unmapped_err: assert property (
    setup && !mapped ##1 access |-> pslverr && prdata == 32'h0)
  else
    $error("unmapped access not refused");

  a_gain_field_ch1: assert property (
    wr_gain && apb_req.pwdata[7:4] <= CSD_GAIN_MAX_CODE
    ##1 quiet
    |=> isense_cfg.gain_code[1] == $past(apb_req.pwdata[7:4], 2))
  else
    $error("channel 1 gain field misplaced");

  a_gain_field_ch2: assert property (
    wr_gain && apb_req.pwdata[11:8] <= CSD_GAIN_MAX_CODE
    ##1 quiet
    |=> isense_cfg.gain_code[2] == $past(apb_req.pwdata[11:8], 2))
  else
    $error("channel 2 gain field misplaced");

  a_gain_over_ch0: assert property (
    wr_gain && apb_req.pwdata[3:0] > CSD_GAIN_MAX_CODE
    ##1 quiet
    |=> isense_cfg.gain_code[0] == CSD_GAIN_DEF_CODE &&
        isense_cfg.gain_x4[0] == 12'h019)
  else
    $error("illegal channel 0 code not mapped to default");

  a_gain_mid: assert property (
    wr_gain && apb_req.pwdata[15:12] == 4'h4
    ##1 quiet
    |=> isense_cfg.gain_x4[3] == 12'h096)
  else
    $error("middle gain code wrong");

  a_rst_isense: assert property (
    $rose(arst_n)
    |-> isense_cfg.filt_en == 4'h0 && isense_cfg.bg_en == 4'h0 &&
        isense_cfg.gain_code == 16'h0000 && isense_cfg.gain_x4 == {4{12'h019}})
  else
    $error("current-sense controls not at reset values");

  a_rst_clamp: assert property (
    $rose(arst_n)
    |-> st_reg.clamp0 == 16'hff00 && st_reg.clamp1 == 16'hff00 && dac_ctl == '0)
  else
    $error("clamp registers not at reset values");

  a_snooze_uni: assert property (
    (first_clamp_pin && !second_clamp_pin && quiet) [*4]
    |-> dac_ctl.uni_snooze == (st_reg.clamp0[3:0] & st_reg.clamp0[11:8]))
  else
    $error("unipolar snooze map wrong");

  a_rsvd_write: assert property (
    wr_bg |=> st_reg.bg[15:12] == 4'h0 && st_reg.bg[7:4] == 4'h0)
  else
    $error("reserved bits took a write");

  a_pin1_split: assert property (
    wr_c1 |=> $stable(st_reg.clamp0) && st_reg.clamp1 == $past(apb_req.pwdata[15:0]))
  else
    $error("second clamp register write leaked");

  a_bg_hold: assert property (
    (wr_gain || wr_c0 || wr_c1) |=> $stable(st_reg.bg))
  else
    $error("background register changed by another write");

  a_read_pin1: assert property (
    setup && !apb_req.pwrite && hit_c1 |=> prdata == {16'h0, st_reg.clamp1})
  else
    $error("second clamp register read wrong");

  a_gain_raw_read: assert property (
    setup && !apb_req.pwrite && hit_gain |=> prdata == {16'h0, st_reg.gain})
  else
    $error("gain register does not read back as written");

endmodule

// ---- tb_top.sv ----
// Purpose: Self-checking bench for the current-sense and DAC clamp register bank
// Assumes: Zero-wait APB slave, clamp pins two-flop synchronised
// Notes: Shadow registers model the bank; random data from an LFSR
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import csd_pkg::*;
  localparam logic [CSD_IW-1:0] IDX [4] = '{CSD_IDX_BG, CSD_IDX_GAIN, CSD_IDX_CLAMP0,
    CSD_IDX_CLAMP1};
  localparam logic [15:0] MASK [4] = '{16'h0f0f, 16'hffff, 16'hffff, 16'hffff};
  localparam logic [7:0] BAD [4] = '{8'h78, 8'h84, 8'h71, 8'h00};
  // Gain times four for codes 0 to 10
  localparam logic [11:0] GX4 [11] = '{12'h019, 12'h032, 12'h04b, 12'h064, 12'h096,
    12'h0c8, 12'h12c, 12'h190, 12'h320, 12'h640, 12'hc35};
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic pin0 = 1'b0;
  logic pin1 = 1'b0;
  csd_apb_req_t apb_req = '0;
  logic pready;
  logic pslverr;
  logic err;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] lfsr = 32'ha4f0ff9f;
  logic [15:0] sh [4];
  csd_isense_cfg_t isense_cfg;
  csd_dac_ctl_t dac_ctl;
  int num_errors = 0;
  int comparisons = 0;

  always #20 clk = ~clk;

  csd_regs uut (.clk(clk), .arst_n(arst_n), .apb_req(apb_req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr), .first_clamp_pin(pin0),
    .second_clamp_pin(pin1), .isense_cfg(isense_cfg), .dac_ctl(dac_ctl));

  function automatic logic [31:0] step(logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  function automatic csd_isense_cfg_t exp_cfg();
    csd_isense_cfg_t e;
    e.filt_en = sh[0][11:8];
    e.bg_en = sh[0][3:0];
    for (int i = 0; i < 4; i++)
    begin
      e.gain_code[i] = (sh[1][4*i+:4] > 4'ha) ? 4'h0 : sh[1][4*i+:4];
      e.gain_x4[i] = GX4[e.gain_code[i]];
    end
    return e;
  endfunction

  function automatic csd_dac_ctl_t exp_dac();
    csd_dac_ctl_t e;
    logic [3:0] a0;
    logic [3:0] a1;
    a0 = {4{pin0}};
    a1 = {4{pin1}};
    e.bi_clamp = a0 & sh[2][7:4] | a1 & sh[3][7:4];
    e.uni_clamp = a0 & sh[2][3:0] | a1 & sh[3][3:0];
    e.bi_snooze = a0 & sh[2][7:4] & sh[2][15:12] | a1 & sh[3][7:4] & sh[3][15:12];
    e.uni_snooze = a0 & sh[2][3:0] & sh[2][11:8] | a1 & sh[3][3:0] & sh[3][11:8];
    return e;
  endfunction

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input logic [71:0] got, input logic [71:0] exp, input string what);
    comparisons++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, what, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk);
    apb_req.psel <= 1'b1;
    apb_req.penable <= 1'b0;
    apb_req.pwrite <= wr;
    apb_req.paddr <= a;
    apb_req.pwdata <= d;
    @(posedge clk);
    apb_req.penable <= 1'b1;
    for (n = 0; n < 20; n++)
    begin
      @(posedge clk);
      if (pready === 1'b1)
        break;
    end
    if (n == 20)
    begin
      num_errors++;
      $display("unexpected at %0t: no pready", $time);
      close_out();
    end
    rd = prdata;
    err = pslverr;
    apb_req.psel <= 1'b0;
    apb_req.penable <= 1'b0;
  endtask

  task automatic wr_reg(input int i, input logic [31:0] d);
    apb(1'b1, {IDX[i], 2'b00}, d);
    sh[i] = d[15:0] & MASK[i];
  endtask

  task automatic check_outs();
    repeat (4) @(posedge clk);
    chk(isense_cfg, exp_cfg(), "isense_cfg");
    chk(dac_ctl, exp_dac(), "dac_ctl");
  endtask

  task automatic check_regs();
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b0, {IDX[i], 2'b00}, 32'h0);
      chk({err, rd}, {1'b0, 16'h0, sh[i]}, "readback");
    end
    check_outs();
  endtask

  task automatic do_reset();
    arst_n <= 1'b0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    sh = '{16'h0000, 16'h0000, 16'hff00, 16'hff00};
  endtask

  initial
  begin
    do_reset();
    check_regs();
    $display("test reset values done");
    // All ones first, so reserved bits are hit
    for (int i = 0; i < 4; i++)
      wr_reg(i, 32'hffffffff);
    pin0 <= 1'b1;
    pin1 <= 1'b1;
    check_regs();
    for (int k = 0; k < 60; k++)
    begin
      lfsr = step(lfsr);
      wr_reg(lfsr[1:0], {lfsr[7:0], lfsr[31:8]});
      pin0 <= lfsr[20];
      pin1 <= lfsr[25];
      check_outs();
    end
    check_regs();
    $display("test random traffic done");
    for (int c = 0; c < 16; c++)
    begin
      wr_reg(1, {16'h0, 4'(c) ^ 4'h3, 4'(c) ^ 4'h2, 4'(c) ^ 4'h1, 4'(c)});
      check_outs();
    end
    $display("test gain codes done");
    foreach (BAD[j])
    begin
      apb(1'b1, BAD[j], 32'hffffffff);
      chk(err, 1'b1, "write error");
      apb(1'b0, BAD[j], 32'h0);
      chk({err, rd}, {1'b1, 32'h0}, "unmapped read");
    end
    check_regs();
    $display("test unmapped done");
    do_reset();
    check_regs();
    $display("test second reset done");
    close_out();
  end

  initial
  begin
    repeat (100000) @(posedge clk);
    num_errors++;
    $display("unexpected at %0t: run too long", $time);
    close_out();
  end
endmodule
